// >>> hw/rwc_sequencer.sv
/*
  Reset, wake and configuration sequencer: holds the core in reset through
  power-on, power-up delay, oscillator start-up and brown-out, and ends sleep.
  Assumes pins and oscillator status arrive asynchronously to clk.
*/
// Notes on behaviour
// - Power-up delay only after power-on or brown-out
// - Crystal modes wait for oscillator start-up
// - Brown-out resets, using power-up delay
// - Wake on reset pin, watchdog, interrupt
// - Programmed bit reads 0, unprogrammed 1
// - Configuration word lives at 2007h
// - Config space only in programming mode
// - Brown-out field decode: 11,10,01,00
`timescale 1ns/100ps
module rwc_sequencer #(
  parameter int PowerUpCycles = rwc_pkg::PowerUpDelayCycles,
  parameter int OscCycles = rwc_pkg::OscStartupCycles
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic powerOnPulse,
  input wire logic brownoutDetect,
  input wire logic externalReset_n,
  input wire logic oscClockTick,
  input wire logic watchdog_wake_source,
  input wire logic interruptWake,
  input wire logic sleepRequest,
  input wire logic software_brownout_enable,
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progWriteData,
  output logic [13:0] progReadData,
  output logic coreReset,
  output logic sleeping,
  output logic brownout_reset_source,
  output logic [1:0] brownout_select_field
);
  // Decoded configuration
  rwc_cfg_if cfg ();
  logic [13:0] progData;

  // Configuration word store
  rwc_config_store u_store (
    .clk(clk),
    .arst_n(arst_n),
    .progMode(progMode),
    .progWrite(progWrite),
    .progAddr(progAddr),
    .progWriteData(progWriteData),
    .progReadData(progData),
    .cfg(cfg)
  );

  // Synchroniser chains for asynchronous inputs
  logic [5:0] sync1_reg;
  logic [5:0] sync2_reg;
  logic oscTickPrev_reg;
  logic porSync;
  logic borSync;
  logic extSync_n;
  logic oscSync;
  logic wdtSync;
  logic intSync;

  // Two flip-flops per input
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= 6'h04;
      sync2_reg <= 6'h04;
      oscTickPrev_reg <= 1'b0;
    end else begin
      sync1_reg <= {interruptWake, watchdog_wake_source, oscClockTick, externalReset_n,
        brownoutDetect, powerOnPulse};
      sync2_reg <= sync1_reg;
      oscTickPrev_reg <= sync2_reg[3];
    end
  end

  assign porSync = sync2_reg[0];
  assign borSync = sync2_reg[1];
  assign extSync_n = sync2_reg[2];
  assign oscSync = sync2_reg[3] && !oscTickPrev_reg;
  assign wdtSync = sync2_reg[4];
  assign intSync = sync2_reg[5];

  // State and counters
  rwc_pkg::rwc_state_type state_reg;
  rwc_pkg::rwc_state_type state_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  // Power-up delay armed by power-on or brown-out, never by the pin
  logic borArmed_reg;
  logic borArmed_next;
  logic borEnable;
  logic isCrystal;
  logic borHit;
  logic coreReset_reg;
  logic coreReset_next;
  logic sleeping_reg;
  logic sleeping_next;
  logic borFlag_reg;
  logic borFlag_next;

  // Brown-out enable and crystal decode
  always_comb begin
    case (cfg.brownoutSelectField)
      rwc_pkg::BrownoutAlways: borEnable = 1'b1;
      rwc_pkg::BrownoutAwake: borEnable = (state_reg != rwc_pkg::ST_SLEEP);
      rwc_pkg::BrownoutSoftware: borEnable = software_brownout_enable;
      default: borEnable = 1'b0;
    endcase
    isCrystal = (cfg.oscSelect == rwc_pkg::OscLowPowerCrystal)
      || (cfg.oscSelect == rwc_pkg::OscCrystal)
      || (cfg.oscSelect == rwc_pkg::OscHighSpeed);
    borHit = borEnable && borSync;
  end

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    borArmed_next = borArmed_reg;
    borFlag_next = borFlag_reg;
    if (porSync) begin
      // Power-on restarts and arms the delay
      state_next = rwc_pkg::ST_HOLD;
      borArmed_next = 1'b1;
      borFlag_next = 1'b0;
      count_next = 32'h0;
    end else if (borHit) begin
      state_next = rwc_pkg::ST_HOLD;
      borArmed_next = 1'b1;
      borFlag_next = 1'b1;
      count_next = 32'h0;
    end else if (!extSync_n) begin
      // External reset: no power-up delay
      state_next = rwc_pkg::ST_HOLD;
      borArmed_next = 1'b0;
      count_next = 32'h0;
    end else begin
      case (state_reg)
        rwc_pkg::ST_HOLD: begin
          // Delay only after power-on or brown-out
          // The pin clears the arm, so a pin reset never waits
          if (cfg.powerUpEnable && borArmed_reg) begin
            state_next = rwc_pkg::ST_POWERUP;
          end else begin
            state_next = rwc_pkg::ST_OSCWAIT;
          end
          count_next = 32'h0;
        end
        rwc_pkg::ST_POWERUP: begin
          if (count_reg >= 32'(PowerUpCycles - 1)) begin
            state_next = rwc_pkg::ST_OSCWAIT;
            count_next = 32'h0;
            borArmed_next = 1'b0;
          end else begin
            count_next = count_reg + 32'h1;
          end
        end
        rwc_pkg::ST_OSCWAIT: begin
          if (!isCrystal || count_reg >= 32'(OscCycles)) begin
            state_next = rwc_pkg::ST_RUN;
            count_next = 32'h0;
          end else if (oscSync) begin
            count_next = count_reg + 32'h1;
          end
        end
        rwc_pkg::ST_RUN: begin
          if (sleepRequest) begin
            state_next = rwc_pkg::ST_SLEEP;
          end
        end
        rwc_pkg::ST_SLEEP: begin
          if (wdtSync || intSync) begin
            state_next = rwc_pkg::ST_RUN;
          end
        end
        default: state_next = rwc_pkg::ST_HOLD;
      endcase
    end
    // Core runs only in run or sleep
    coreReset_next = !(state_next == rwc_pkg::ST_RUN || state_next == rwc_pkg::ST_SLEEP);
    sleeping_next = (state_next == rwc_pkg::ST_SLEEP);
  end

  // Register the sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= rwc_pkg::ST_HOLD;
      count_reg <= 32'h0;
      // Release of the reset input counts as a power-on
      borArmed_reg <= 1'b1;
      borFlag_reg <= 1'b0;
      coreReset_reg <= 1'b1;
      sleeping_reg <= 1'b0;
      progReadData <= 14'h0000;
      brownout_select_field <= 2'h3;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      borArmed_reg <= borArmed_next;
      borFlag_reg <= borFlag_next;
      coreReset_reg <= coreReset_next;
      sleeping_reg <= sleeping_next;
      progReadData <= progData;
      brownout_select_field <= cfg.brownoutSelectField;
    end
  end

  assign coreReset = coreReset_reg;
  assign sleeping = sleeping_reg;
  assign brownout_reset_source = borFlag_reg;
endmodule

// >>> hw/rwc_pkg.sv
/*
  Shared constants and types for the reset, wake and configuration sequencer.
  Assumes a 125 MHz system clock and a 14-bit program address.
*/
package rwc_pkg;
  // System clock period in nanoseconds
  localparam int ClkPeriodNs = 8;
  // Power-up delay, nominal, in milliseconds
  localparam int PowerUpDelayMs = 64;
  // Power-up delay in clock cycles
  localparam int PowerUpDelayCycles = PowerUpDelayMs * 1000000 / ClkPeriodNs;
  // Oscillator start-up count in oscillator cycles
  localparam int OscStartupCycles = 1024;
  // Configuration word location
  localparam logic [13:0] ConfigWordAddr = 14'h2007;
  // Configuration space bounds
  localparam logic [13:0] ConfigSpaceLow = 14'h2000;
  localparam logic [13:0] ConfigSpaceHigh = 14'h3FFF;
  // Value of the configuration word after reset (all unprogrammed)
  localparam logic [13:0] ConfigResetValue = 14'h3FFF;
  // Field positions inside the configuration word
  localparam int BrownoutSelLsb = 8;
  localparam int PowerUpEnableBit = 4;
  localparam int OscSelLsb = 0;
  // Brown-out selection encodings
  localparam logic [1:0] BrownoutAlways = 2'h3;
  localparam logic [1:0] BrownoutAwake = 2'h2;
  localparam logic [1:0] BrownoutSoftware = 2'h1;
  localparam logic [1:0] BrownoutOff = 2'h0;
  // Oscillator selection values that name crystal modes
  localparam logic [2:0] OscLowPowerCrystal = 3'h0;
  localparam logic [2:0] OscCrystal = 3'h1;
  localparam logic [2:0] OscHighSpeed = 3'h2;

  // Sequencer states, Gray coded along the start-up path
  typedef enum logic [2:0] {
    ST_HOLD = 3'h0,
    ST_POWERUP = 3'h1,
    ST_OSCWAIT = 3'h3,
    ST_RUN = 3'h2,
    ST_SLEEP = 3'h6
  } rwc_state_type;
endpackage

// >>> hw/rwc_cfg_if.sv
/*
  Interface carrying the decoded configuration options between the word store
  and the sequencer. Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
interface rwc_cfg_if;
  // Brown-out selection field
  logic [1:0] brownoutSelectField;
  // Power-up delay enabled
  logic powerUpEnable;
  // Oscillator selection
  logic [2:0] oscSelect;
  // Raw word
  logic [13:0] configWord;
  modport store (output brownoutSelectField, output powerUpEnable, output oscSelect,
    output configWord);
  modport user (input brownoutSelectField, input powerUpEnable, input oscSelect,
    input configWord);
endinterface

// >>> hw/rwc_config_store.sv
/*
  Configuration word store, reset to all unprogrammed, reachable only in programming mode.
  Assumes the programmer port is synchronous to clk.
*/
`timescale 1ns/100ps
module rwc_config_store (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progWriteData,
  output logic [13:0] progReadData,
  rwc_cfg_if.store cfg
);
  // Stored word; a programmed bit holds 0
  logic [13:0] word_reg;
  logic [13:0] word_next;
  logic [13:0] rdata_reg;
  logic [13:0] rdata_next;
  logic hit;

  // Next word and read data
  always_comb begin
    hit = progMode && (progAddr >= rwc_pkg::ConfigSpaceLow)
      && (progAddr <= rwc_pkg::ConfigSpaceHigh);
    word_next = word_reg;
    rdata_next = rdata_reg;
    if (hit && progAddr == rwc_pkg::ConfigWordAddr) begin
      if (progWrite) begin
        word_next = progWriteData;
      end
      rdata_next = word_reg;
    end else if (hit) begin
      // Other config locations read unprogrammed
      rdata_next = rwc_pkg::ConfigResetValue;
    end else begin
      rdata_next = 14'h0000;
    end
  end

  // Register stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= rwc_pkg::ConfigResetValue;
      rdata_reg <= 14'h0000;
    end else begin
      word_reg <= word_next;
      rdata_reg <= rdata_next;
    end
  end

  assign progReadData = rdata_reg;
  assign cfg.configWord = word_reg;
  assign cfg.brownoutSelectField = word_reg[rwc_pkg::BrownoutSelLsb +: 2];
  assign cfg.powerUpEnable = ~word_reg[rwc_pkg::PowerUpEnableBit];
  assign cfg.oscSelect = word_reg[rwc_pkg::OscSelLsb +: 3];
endmodule

// >>> tb/rwc_prog_model.sv
/*
  External programmer model for the configuration space.
  Assumes the bench clock; drives only at the falling edge.
*/
`timescale 1ns/100ps
module rwc_prog_model (
  input wire logic clk,
  output logic progMode,
  output logic progWrite,
  output logic [13:0] progAddr,
  output logic [13:0] progWriteData,
  input wire logic [13:0] progReadData
);
  // Idle programmer: mode off, bus showing junk
  initial begin
    progMode = 1'b0;
    progWrite = 1'b0;
    progAddr = 14'h1555;
    progWriteData = 14'h2AAA;
  end

  task automatic access(input logic m, input logic w, input logic [13:0] a,
    input logic [13:0] d, output logic [13:0] q);
    @(negedge clk);
    progMode = m;
    progWrite = w;
    progAddr = a;
    progWriteData = d;
    @(negedge clk);
    progWrite = 1'b0;
    // Data lands two cycles after the address
    repeat (2) @(negedge clk);
    q = progReadData;
    // Released bus shows the inverse, not a stale value
    progMode = 1'b0;
    progAddr = ~a;
    progWriteData = ~d;
  endtask
endmodule

// >>> tb/rwc_sequencer_chk.sv
/*
  Port checker for the sequencer.
  Bound onto rwc_sequencer from the bench top file.
*/
`timescale 1ns/100ps
module rwc_sequencer_chk #(
  parameter int PowerUpCycles = 20,
  parameter int OscCycles = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic powerOnPulse,
  input wire logic brownoutDetect,
  input wire logic externalReset_n,
  input wire logic watchdog_wake_source,
  input wire logic interruptWake,
  input wire logic progMode,
  input wire logic progWrite,
  input wire logic [13:0] progAddr,
  input wire logic [13:0] progWriteData,
  input wire logic [13:0] progReadData,
  input wire logic coreReset,
  input wire logic sleeping,
  input wire logic brownout_reset_source,
  input wire logic [1:0] brownout_select_field
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // No reset cause apart from brown-out
  logic quiet;
  assign quiet = externalReset_n && !powerOnPulse;
  // Brown-out field bits of the word on the programmer bus
  logic [1:0] wrField;
  assign wrField = progWriteData[rwc_pkg::BrownoutSelLsb +: 2];
  // Field copy follows a stored word: word one edge, copy the next
  property fieldFollows;
    progMode && progWrite && progAddr == rwc_pkg::ConfigWordAddr
      |-> ##2 brownout_select_field == $past(wrField, 2);
  endproperty
  AST_REFUSE: assert property ((!progMode)[*3] |-> progReadData == 14'h0)
    else $error("read data seen outside programming mode");
  AST_SPACE: assert property (
    (progMode && progAddr >= 14'h2000 && progAddr != 14'h2007)[*3] |-> progReadData == 14'h3FFF)
    else $error("empty config location not all ones");
  AST_USER: assert property ((progMode && progAddr < 14'h2000)[*3] |-> progReadData == 14'h0)
    else $error("user space visible through config port");
  AST_FIELD: assert property (fieldFollows)
    else $error("brown-out field not taken from word");
  AST_BOR: assert property (
    (brownoutDetect && brownout_select_field == rwc_pkg::BrownoutAlways)[*3]
      |-> ##[0:4] (coreReset && brownout_reset_source))
    else $error("brown-out did not reset");
  AST_QUIET: assert property (
    (!coreReset && quiet && (!brownoutDetect || brownout_select_field == 2'h0))[*4] |=> !coreReset)
    else $error("reset without a cause");
  AST_SLEEP_BOR: assert property (
    (sleeping && brownout_select_field == rwc_pkg::BrownoutAwake && quiet
      && !watchdog_wake_source && !interruptWake)[*4] |=> !coreReset)
    else $error("brown-out acted in sleep");
  AST_WAKE: assert property (
    sleeping && (watchdog_wake_source || interruptWake) |-> ##[1:4] !sleeping)
    else $error("no wake from watchdog or interrupt");
  AST_EXT_WAKE: assert property (
    sleeping && !externalReset_n |-> ##[1:4] (coreReset && !sleeping))
    else $error("no wake from reset pin");
  cover property ($rose(sleeping));
  cover property ($rose(brownout_reset_source));
  cover property ($fell(coreReset));
endmodule

// >>> tb/rwc_sequencer_tb.sv
/*
  Self-checking bench for the sequencer with a programmer model.
  Assumes shortened counts: 20 power-up cycles, 4 oscillator edges.
*/
`timescale 1ns/100ps
module rwc_sequencer_tb;
  logic clk = 1'b0, arst_n = 1'b0, powerOnPulse = 1'b0, brownoutDetect = 1'b0;
  logic externalReset_n = 1'b1, oscClockTick = 1'b0, oscRun = 1'b0, watchdogWake = 1'b0;
  logic interruptWake = 1'b0, sleepRequest = 1'b0, softBrownoutEnable = 1'b0;
  logic progMode, progWrite, coreReset, sleeping, brownoutFlag;
  logic [13:0] progAddr, progWriteData, progReadData, q;
  logic [1:0] brownoutField;
  int badCount = 0, checkCount = 0, n;
  always #4 clk = ~clk;
  // Crystal edges, stopped when oscRun is low
  always @(negedge clk) if (oscRun) oscClockTick <= ~oscClockTick;
  rwc_sequencer #(.PowerUpCycles(20), .OscCycles(4)) i_rwc_sequencer (.clk(clk),
    .arst_n(arst_n), .powerOnPulse(powerOnPulse), .brownoutDetect(brownoutDetect),
    .externalReset_n(externalReset_n), .oscClockTick(oscClockTick),
    .watchdog_wake_source(watchdogWake), .interruptWake(interruptWake),
    .sleepRequest(sleepRequest), .software_brownout_enable(softBrownoutEnable),
    .progMode(progMode), .progWrite(progWrite), .progAddr(progAddr),
    .progWriteData(progWriteData), .progReadData(progReadData), .coreReset(coreReset),
    .sleeping(sleeping), .brownout_reset_source(brownoutFlag),
    .brownout_select_field(brownoutField));
  rwc_prog_model i_rwc_prog_model (.clk(clk), .progMode(progMode), .progWrite(progWrite),
    .progAddr(progAddr), .progWriteData(progWriteData), .progReadData(progReadData));
  // Compare and count
  task check(input string nm, input logic [13:0] s, input logic [13:0] e);
    checkCount++;
    if (s !== e) begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task giveVerdict;
    $display("checks %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Cycles until the core is released, bounded
  task relWait(output int c);
    c = 0;
    while (coreReset !== 1'b0 && c < 300) begin
      @(negedge clk);
      c++;
    end
    check("released", {13'h0, coreReset}, 14'h0);
  endtask
  // Pulse one input for a few cycles
  task automatic pulse(ref logic s, input logic v, input int c);
    @(negedge clk);
    s = v;
    repeat (c) @(negedge clk);
    s = ~v;
    repeat (4) @(negedge clk);
  endtask
  task t_config;
    i_rwc_prog_model.access(1'b1, 1'b1, 14'h2007, 14'h3EE8, q);
    i_rwc_prog_model.access(1'b1, 1'b0, 14'h2007, 14'h0, q);
    check("word", q, 14'h3EE8);
    i_rwc_prog_model.access(1'b1, 1'b0, 14'h2001, 14'h0, q);
    check("space", q, 14'h3FFF);
    i_rwc_prog_model.access(1'b1, 1'b0, 14'h1FFF, 14'h0, q);
    check("user", q, 14'h0);
    i_rwc_prog_model.access(1'b0, 1'b1, 14'h2007, 14'h0, q);
    check("refused", q, 14'h0);
    i_rwc_prog_model.access(1'b1, 1'b0, 14'h2007, 14'h0, q);
    check("kept", q, 14'h3EE8);
    check("field", {12'h0, brownoutField}, 14'h2);
  endtask
  // Fields 00, 01 off, 01 on, 10, 11 while running
  task t_brownout;
    logic [9:0] fl;
    logic [4:0] sb, ex;
    fl = 10'h394;
    sb = 5'h04;
    ex = 5'h1C;
    oscRun = 1'b1;
    for (int i = 0; i < 5; i++) begin
      i_rwc_prog_model.access(1'b1, 1'b1, 14'h2007, 14'h3CE8 | {4'h0, fl[2*i+:2], 8'h0}, q);
      softBrownoutEnable = sb[i];
      pulse(brownoutDetect, 1'b1, 3);
      check("borReset", {13'h0, coreReset}, {13'h0, ex[i]});
      if (ex[i]) begin
        relWait(n);
        check("borDelay", {13'h0, n >= 16}, 14'h1);
        check("borFlag", {13'h0, brownoutFlag}, 14'h1);
      end
    end
  endtask
  task t_power_on;
    pulse(powerOnPulse, 1'b1, 2);
    relWait(n);
    check("pwrDelay", {13'h0, n >= 16}, 14'h1);
    check("flagClr", {13'h0, brownoutFlag}, 14'h0);
  endtask
  task t_ext_reset;
    oscRun = 1'b0;
    pulse(externalReset_n, 1'b0, 2);
    repeat (40) @(negedge clk);
    check("oscHold", {13'h0, coreReset}, 14'h1);
    oscRun = 1'b1;
    relWait(n);
    check("noDelay", {13'h0, n < 20}, 14'h1);
    // High-speed crystal running: pin reset waits only for start-up
    i_rwc_prog_model.access(1'b1, 1'b1, 14'h2007, 14'h3CEA, q);
    pulse(externalReset_n, 1'b0, 2);
    relWait(n);
    check("extNoDelay", {13'h0, n < 16}, 14'h1);
    // Non-crystal option: no start-up wait even with the crystal stopped
    oscRun = 1'b0;
    i_rwc_prog_model.access(1'b1, 1'b1, 14'h2007, 14'h3CEB, q);
    pulse(externalReset_n, 1'b0, 2);
    relWait(n);
    check("noOscWait", {13'h0, n < 4}, 14'h1);
    oscRun = 1'b1;
  endtask
  task t_sleep;
    i_rwc_prog_model.access(1'b1, 1'b1, 14'h2007, 14'h3EE8, q);
    pulse(sleepRequest, 1'b1, 1);
    pulse(brownoutDetect, 1'b1, 6);
    check("sleepBor", {12'h0, coreReset, sleeping}, 14'h1);
    pulse(watchdogWake, 1'b1, 2);
    check("wdWake", {13'h0, sleeping}, 14'h0);
    pulse(sleepRequest, 1'b1, 1);
    pulse(interruptWake, 1'b1, 2);
    check("intWake", {13'h0, sleeping}, 14'h0);
    pulse(sleepRequest, 1'b1, 1);
    @(negedge clk);
    externalReset_n = 1'b0;
    repeat (5) @(negedge clk);
    check("pinWake", {12'h0, coreReset, sleeping}, 14'h2);
    externalReset_n = 1'b1;
    relWait(n);
  endtask
  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    check("rstOut", {10'h0, coreReset, sleeping, brownoutField}, 14'hB);
    check("rstFlag", {13'h0, brownoutFlag}, 14'h0);
    relWait(n);
    t_config;
    t_brownout;
    t_power_on;
    t_ext_reset;
    t_sleep;
    giveVerdict;
  end
  // Hang guard, far beyond the expected few hundred cycles
  initial begin
    #200000;
    badCount++;
    giveVerdict;
  end
endmodule
bind rwc_sequencer rwc_sequencer_chk #(.PowerUpCycles(PowerUpCycles), .OscCycles(OscCycles))
  i_rwc_sequencer_chk (.clk(clk), .arst_n(arst_n), .powerOnPulse(powerOnPulse),
  .brownoutDetect(brownoutDetect), .externalReset_n(externalReset_n),
  .watchdog_wake_source(watchdog_wake_source), .interruptWake(interruptWake),
  .progMode(progMode), .progWrite(progWrite), .progAddr(progAddr),
  .progWriteData(progWriteData), .progReadData(progReadData), .coreReset(coreReset),
  .sleeping(sleeping), .brownout_reset_source(brownout_reset_source),
  .brownout_select_field(brownout_select_field));
